// ---- bsp_params.svh ----
// Constants for the byte serial master port: counts, sizes and reset values.
`ifndef BSP_PARAMS_SVH
`define BSP_PARAMS_SVH

// Link clock cycles per half period of the serial clock.
`define BSP_HALF_DIV      4
// Link clock cycles of enforced idle time after each byte.
`define BSP_GAP_CYCLES    8
// Receive FIFO depth in bytes.
`define BSP_FIFO_DEPTH    32
// Index of the last bit of a byte.
`define BSP_BIT_LAST      3'h7
// Transmit descriptors left to the third serial channel.
`define BSP_DESC_FULL     4'h8
`define BSP_DESC_SHARED   4'h4
// Reset value of data registers.
`define BSP_RESET_BYTE    8'h00

`endif

// ---- bsp_pkg.sv ----
// Types shared by the byte serial master port files.
`default_nettype none
package bsp_pkg;

  typedef logic [7:0] bsp_byte_t;

  // Request word handed from the system domain to the link domain.
  typedef struct packed {
    logic      inv;
    bsp_byte_t data;
  } bsp_xfer_s;

  typedef enum logic [2:0] {
    L_IDLE,
    L_SETUP,
    L_LEAD,
    L_TRAIL,
    L_GAP
  } bsp_link_state_e;

endpackage
`default_nettype wire

// ---- bsp_fifo.sv ----
// Synchronous FIFO with a registered output stage.
`default_nettype none
module bsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      total;
  logic             load_out;
  logic             mem_empty;
  logic             push;
  logic             pop_mem;
  logic             bypass;
  logic             write_mem;

  // The output register counts as one of the DEPTH words.
  assign total     = count + {{AW{1'b0}}, out_valid};
  assign in_ready  = total < (AW+1)'(DEPTH);
  assign load_out  = !out_valid || out_ready;
  assign mem_empty = count == '0;
  assign push      = in_valid && in_ready;
  assign pop_mem   = load_out && !mem_empty;
  assign bypass    = load_out && mem_empty && push;
  assign write_mem = push && !bypass;

  always_ff @(posedge clk)
  begin
    if (write_mem)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= write_mem ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop_mem ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + {{AW{1'b0}}, write_mem} - {{AW{1'b0}}, pop_mem};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (load_out)
    begin
      out_valid <= !mem_empty || push;
      out_data  <= pop_mem ? mem[rd_ptr] : (bypass ? in_data : out_data);
    end
  end

endmodule
`default_nettype wire

// ---- bsp_byte_serial_master_port.sv ----
// Byte serial master port: host control, link shifter and receive FIFO.
//
// Operation
// [RQ1] Each start command shifts exactly one byte from the descriptor out.
// [RQ2] A receive byte is shifted in over the same clock edges.
// [RQ3] The port always drives the serial clock; no slave mode exists.
// [RQ4] The partner times its bits from our clock and supplies none.
// [RQ5] A completion pulse per byte lets the host take one interrupt.
// [RQ6] Bytes never follow back to back; an idle gap separates them.
// [RQ7] Clock invert low: transmit changes on rising, receive samples falling.
// [RQ8] Clock invert high: transmit changes on falling, samples on rising.
// [RQ9] Port in use leaves four transmit descriptors to the third channel.
// [RQ10] After eight bits the start bit clears and the byte is stored.
`default_nettype none
`include "bsp_params.svh"
module bsp_byte_serial_master_port
  import bsp_pkg::*;
#(
  parameter int HALF_DIV   = `BSP_HALF_DIV,
  parameter int GAP_CYCLES = `BSP_GAP_CYCLES,
  parameter int FIFO_DEPTH = `BSP_FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic      SYS_CLK,
  input  wire logic      RESETN,
  // Link clock
  input  wire logic      LINK_CLK,
  // Host control
  input  wire logic      PORT_ENABLE,
  input  wire logic      CLOCK_INVERT,
  input  wire logic      START,
  input  wire bsp_byte_t TX_BYTE,
  output logic           START_READY,
  output logic           START_BIT,
  output logic           BYTE_DONE,
  output logic [3:0]     THIRD_CHAN_TX_DESC,
  // Received bytes
  output logic           RX_VALID,
  input  wire logic      RX_READY,
  output bsp_byte_t      RX_DATA,
  // Serial pins
  output logic           SERIAL_CLOCK,
  output logic           SERIAL_PORT_TX_DATA,
  input  wire logic      SERIAL_PORT_RX_DATA
);

  // System domain.
  logic      busy;
  logic      req_tg;
  bsp_xfer_s req_word;
  logic      ack_meta;
  logic      ack_sync;
  logic      ack_seen;
  logic      done_evt;
  logic      fifo_in_ready;
  logic      start_take;
  logic      byte_done;
  logic [3:0] desc_count;

  // Link domain.
  logic            lrst_meta;
  logic            lrst_n;
  logic            req_meta;
  logic            req_sync;
  logic            req_seen;
  logic            rx_meta;
  logic            rx_sync;
  bsp_link_state_e lstate;
  bsp_link_state_e next_lstate;
  logic [7:0]      div_cnt;
  logic [7:0]      gap_cnt;
  logic [2:0]      bit_cnt;
  logic            inv_act;
  logic            sck;
  logic            tx_bit;
  bsp_byte_t       tx_sh;
  bsp_byte_t       rx_sh;
  bsp_byte_t       rx_hold;
  bsp_byte_t       rx_next;
  logic            ack_tg;
  logic            new_req;
  logic            take_req;
  logic            half_done;
  logic            drive_en;
  logic            sample_en;
  logic            last_bit;
  logic            gap_done;
  logic            shifting;

  // System domain logic.

  // A start needs an idle port and room for the byte it will return.
  assign start_take  = START && !busy && fifo_in_ready && PORT_ENABLE;
  assign START_READY = !busy && fifo_in_ready && PORT_ENABLE;
  assign done_evt    = ack_sync ^ ack_seen;
  assign START_BIT   = busy;
  assign BYTE_DONE   = byte_done;
  assign THIRD_CHAN_TX_DESC = desc_count;

  // The request word is held stable until the link answers.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      req_tg   <= 1'b0;
      req_word <= '0;
    end
    else if (start_take)
    begin
      req_tg   <= ~req_tg;                    // see RQ1
      req_word <= '{inv: CLOCK_INVERT, data: TX_BYTE};
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      busy <= 1'b0;
    end
    else if (start_take)
    begin
      busy <= 1'b1;
    end
    else if (done_evt)
    begin
      busy <= 1'b0;                           // see RQ10
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      ack_meta  <= 1'b0;
      ack_sync  <= 1'b0;
      ack_seen  <= 1'b0;
      byte_done <= 1'b0;
    end
    else
    begin
      ack_meta  <= ack_tg;
      ack_sync  <= ack_meta;
      ack_seen  <= ack_sync;
      byte_done <= done_evt;                  // see RQ5
    end
  end

  // Sharing the controller leaves the third channel fewer descriptors.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      desc_count <= `BSP_DESC_FULL;
    end
    else
    begin
      desc_count <= PORT_ENABLE ? `BSP_DESC_SHARED : `BSP_DESC_FULL; // see RQ9
    end
  end

  // The received byte is stable in rx_hold once the answer toggle is seen.
  bsp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RESETN),
    .in_valid  (done_evt),                    // see RQ10
    .in_ready  (fifo_in_ready),
    .in_data   (rx_hold),
    .out_valid (RX_VALID),
    .out_ready (RX_READY),
    .out_data  (RX_DATA)
  );

  // Link domain logic.

  always_ff @(posedge LINK_CLK)
  begin
    lrst_meta <= RESETN;
    lrst_n    <= lrst_meta;
  end

  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      rx_meta  <= 1'b0;
      rx_sync  <= 1'b0;
    end
    else
    begin
      req_meta <= req_tg;
      req_sync <= req_meta;
      rx_meta  <= SERIAL_PORT_RX_DATA;
      rx_sync  <= rx_meta;
    end
  end

  assign new_req   = req_sync ^ req_seen;
  assign take_req  = (lstate == L_IDLE) && new_req;
  assign shifting  = (lstate == L_SETUP) || (lstate == L_LEAD) ||
                     (lstate == L_TRAIL);
  assign half_done = shifting && (div_cnt == 8'(HALF_DIV - 1));
  assign drive_en  = half_done && (lstate != L_LEAD);
  assign sample_en = half_done && (lstate == L_LEAD);
  assign last_bit  = bit_cnt == `BSP_BIT_LAST;
  assign gap_done  = (lstate == L_GAP) && (gap_cnt == 8'(GAP_CYCLES - 1));
  assign rx_next   = {rx_sh[6:0], rx_sync};

  always_comb
  begin
    next_lstate = lstate;
    case (lstate)
      L_IDLE:  next_lstate = new_req ? L_SETUP : L_IDLE;
      L_SETUP: next_lstate = drive_en ? L_LEAD : L_SETUP;
      L_LEAD:  next_lstate = sample_en ? (last_bit ? L_GAP : L_TRAIL)
                                       : L_LEAD;
      L_TRAIL: next_lstate = drive_en ? L_LEAD : L_TRAIL;
      L_GAP:   next_lstate = gap_done ? L_IDLE : L_GAP;   // see RQ6
      default: next_lstate = L_IDLE;
    endcase
  end

  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      lstate  <= L_IDLE;
      div_cnt <= '0;
      gap_cnt <= '0;
    end
    else
    begin
      lstate  <= next_lstate;
      div_cnt <= (half_done || !shifting) ? '0 : div_cnt + 1'b1;
      gap_cnt <= (lstate == L_GAP) ? gap_cnt + 1'b1 : '0;
    end
  end

  // The clock rests at the invert level and each bit pulses it once.
  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      req_seen <= 1'b0;
      inv_act  <= 1'b0;
      sck      <= 1'b0;
    end
    else if (take_req)
    begin
      req_seen <= req_sync;
      inv_act  <= req_word.inv;
      sck      <= req_word.inv;               // see RQ3
    end
    else if (drive_en)
    begin
      sck <= ~inv_act;                        // see RQ7 RQ8
    end
    else if (sample_en)
    begin
      sck <= inv_act;                         // see RQ7 RQ8
    end
  end

  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      tx_sh   <= `BSP_RESET_BYTE;
      tx_bit  <= 1'b0;
      bit_cnt <= '0;
    end
    else if (take_req)
    begin
      tx_sh   <= req_word.data;
      bit_cnt <= '0;
    end
    else if (drive_en)
    begin
      tx_bit <= tx_sh[7];                     // see RQ1
      tx_sh  <= {tx_sh[6:0], 1'b0};
    end
    else if (sample_en)
    begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      rx_sh   <= `BSP_RESET_BYTE;
      rx_hold <= `BSP_RESET_BYTE;
      ack_tg  <= 1'b0;
    end
    else if (sample_en)
    begin
      rx_sh <= rx_next;                       // see RQ2
      if (last_bit)
      begin
        rx_hold <= rx_next;                   // see RQ10
        ack_tg  <= ~ack_tg;
      end
    end
  end

  // The partner follows this clock only.
  assign SERIAL_CLOCK        = sck;           // see RQ4
  assign SERIAL_PORT_TX_DATA = tx_bit;

  // Checks on the host handshake and the serial timing.

  sequence s_gap_hold;
    (lstate == L_GAP) [*4];
  endsequence

  sequence s_busy_hold;
    busy [*8];
  endsequence

  a_start_sets_busy: assert property (@(posedge SYS_CLK) // see RQ1
    disable iff (!RESETN) start_take |=> s_busy_hold)
    else $error("start bit did not stay set after a start");

  a_done_clears: assert property (@(posedge SYS_CLK) // see RQ10
    disable iff (!RESETN) done_evt |=> !busy && byte_done)
    else $error("start bit not cleared or no pulse after a byte");

  a_done_bounded: assert property (@(posedge SYS_CLK) // see RQ5
    disable iff (!RESETN) start_take |-> ##[1:1000] done_evt)
    else $error("byte transfer did not complete in time");

  a_idle_level: assert property (@(posedge LINK_CLK) // see RQ3
    disable iff (!lrst_n) (lstate == L_IDLE) |-> (sck == inv_act))
    else $error("serial clock not at rest level while idle");

  a_drive_rise: assert property (@(posedge LINK_CLK) // see RQ7
    disable iff (!lrst_n) $changed(tx_bit) && !inv_act |-> $rose(sck))
    else $error("transmit bit changed off the rising edge");

  a_drive_fall: assert property (@(posedge LINK_CLK) // see RQ8
    disable iff (!lrst_n) $changed(tx_bit) && inv_act |-> $fell(sck))
    else $error("transmit bit changed off the falling edge");

  a_sample_edge: assert property (@(posedge LINK_CLK) // see RQ2
    disable iff (!lrst_n) sample_en |=>
    (sck == inv_act) && (rx_sh[0] == $past(rx_sync)))
    else $error("receive bit not sampled on the sample edge");

  a_eight_bits: assert property (@(posedge LINK_CLK) // see RQ1
    disable iff (!lrst_n) $changed(ack_tg) |->
    $past(lstate) == L_LEAD && $past(bit_cnt) == `BSP_BIT_LAST)
    else $error("byte finished after other than eight bits");

  a_gap_min: assert property (@(posedge LINK_CLK) // see RQ6
    disable iff (!lrst_n) $changed(ack_tg) |-> s_gap_hold)
    else $error("idle gap after a byte too short");

endmodule
`default_nettype wire

// ---- bsp_serial_partner.sv ----
// Behavioural serial device that takes its clock from the port.
`default_nettype none
module bsp_serial_partner #(
  parameter int MIN_GAP = 8
) (
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       inv,
  input  wire logic       mosi,
  output logic            miso,
  // Clock for measuring the idle gap
  input  wire logic       link_clk,
  // Bench side
  input  wire logic [7:0] tx_byte,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic [15:0]     edges,
  output logic [7:0]      errs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh_out;
  logic [7:0] sh_in;
  int         nbit = 0;
  int         idle = 0;
  bit         armed = 1'b0;
  bit         live = 1'b0;
  realtime    t_drive = 0;

  initial
  begin
    miso = 1'b1;
    done = 1'b0;
    rx_byte = 8'h00;
    edges = 16'h0000;
    errs = 8'h00;
  end

  always @(posedge link_clk)
    idle = idle + 1;

  // A drive edge leaves the rest level, a sample edge returns to it.
  always @(sclk)
  begin
    if (sclk !== inv)
    begin
      if (nbit == 0)
      begin
        if (live && idle < MIN_GAP) errs = errs + 8'h01;
        sh_out = tx_byte;
        done = 1'b0;
      end
      live = 1'b1;
      armed = 1'b1;
      t_drive = $realtime;
      miso = sh_out[7];
      sh_out = {sh_out[6:0], 1'b0};
    end
    else if (armed)
    begin
      armed = 1'b0;
      idle = 0;
      sh_in = {sh_in[6:0], mosi};
      nbit = nbit + 1;
      edges = edges + 16'h0001;
      if (nbit == 8)
      begin
        nbit = 0;
        // The line is released, so it must not keep showing the last bit.
        miso = ~miso;
        rx_byte = sh_in;
        done = 1'b1;
      end
    end
  end

  // Transmit bits may only move together with a drive edge.
  always @(mosi)
  begin
    #1;
    if (live && ($realtime - t_drive) > 1.5) errs = errs + 8'h01;
  end
endmodule
`default_nettype wire

// ---- bsp_byte_serial_master_port_tb.sv ----
// Self-checking bench for the byte serial master port.
`default_nettype none
module bsp_byte_serial_master_port_tb
  import bsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP   = 8;
  localparam int DEPTH = 32;
  logic       SYS_CLK = 1'b0;
  logic       LINK_CLK = 1'b0;
  logic       RESETN = 1'b0;
  logic       PORT_ENABLE = 1'b0;
  logic       CLOCK_INVERT = 1'b0;
  logic       START = 1'b0;
  logic       RX_READY = 1'b0;
  bsp_byte_t  TX_BYTE = 8'h00;
  bsp_byte_t  p_byte = 8'h00;
  logic       START_READY, START_BIT, BYTE_DONE, RX_VALID;
  logic [3:0] THIRD_CHAN_TX_DESC;
  bsp_byte_t  RX_DATA, p_rx;
  logic       SERIAL_CLOCK, SERIAL_PORT_TX_DATA, SERIAL_PORT_RX_DATA, p_done;
  logic [15:0] edges;
  logic [7:0] errs;
  int         failures = 0;
  int         total_checks = 0;
  int         n_taken = 0;
  int         n_done = 0;
  int         i, k;
  bit         rnd_rdy = 1'b0;
  bsp_byte_t  exp_tx[$];
  bsp_byte_t  exp_rx[$];

  bsp_byte_serial_master_port #(
    .HALF_DIV   (4),
    .GAP_CYCLES (GAP),
    .FIFO_DEPTH (DEPTH)
  ) u_bsp_byte_serial_master_port (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK),
    .PORT_ENABLE(PORT_ENABLE), .CLOCK_INVERT(CLOCK_INVERT),
    .START(START), .TX_BYTE(TX_BYTE), .START_READY(START_READY),
    .START_BIT(START_BIT), .BYTE_DONE(BYTE_DONE),
    .THIRD_CHAN_TX_DESC(THIRD_CHAN_TX_DESC), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .RX_DATA(RX_DATA), .SERIAL_CLOCK(SERIAL_CLOCK),
    .SERIAL_PORT_TX_DATA(SERIAL_PORT_TX_DATA),
    .SERIAL_PORT_RX_DATA(SERIAL_PORT_RX_DATA)
  );

  bsp_serial_partner #(
    .MIN_GAP (GAP)
  ) u_bsp_serial_partner (
    .sclk(SERIAL_CLOCK), .inv(CLOCK_INVERT), .mosi(SERIAL_PORT_TX_DATA),
    .miso(SERIAL_PORT_RX_DATA), .link_clk(LINK_CLK), .tx_byte(p_byte),
    .done(p_done), .rx_byte(p_rx), .edges(edges), .errs(errs)
  );

  always #10 SYS_CLK = ~SYS_CLK;

  initial
  begin
    #3.2;
    forever #7.5 LINK_CLK = ~LINK_CLK;
  end

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input bsp_byte_t got, input bsp_byte_t exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One byte: wait for readiness, start, try a refused start, await done.
  task automatic send(input logic inv);
    int n;
    n = 0;
    while (START_READY !== 1'b1 && n < 3000)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    if (n >= 3000) failures++;
    TX_BYTE = 8'($urandom);
    p_byte = 8'($urandom);
    CLOCK_INVERT = inv;
    START = 1'b1;
    exp_tx.push_back(TX_BYTE);
    exp_rx.push_back(p_byte);
    n_taken++;
    @(negedge SYS_CLK);
    TX_BYTE = 8'($urandom);
    check_bit(START_BIT, 1'b1);
    check_bit(START_READY, 1'b0);
    @(negedge SYS_CLK);
    START = 1'b0;
    n = 0;
    while (BYTE_DONE !== 1'b1 && n < 3000)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    if (n >= 3000) failures++;
    check_bit(START_BIT, 1'b0);
    @(negedge SYS_CLK);
    check_bit(BYTE_DONE, 1'b0);
  endtask

  always @(negedge SYS_CLK)
    if (rnd_rdy) RX_READY = 1'($urandom);

  always @(posedge SYS_CLK)
  begin
    if (BYTE_DONE === 1'b1) n_done++;
    if (RX_VALID === 1'b1 && RX_READY === 1'b1)
    begin
      if (exp_rx.size() > 0)
        check_byte(RX_DATA, exp_rx.pop_front());
      else
        failures++;
    end
  end

  always @(posedge p_done)
    if (exp_tx.size() > 0) check_byte(p_rx, exp_tx.pop_front());
    else failures++;

  initial
  begin
    #500us;
    failures++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(56177));
    repeat (2) @(negedge SYS_CLK);
    check_byte({4'h0, THIRD_CHAN_TX_DESC}, 8'h08);
    check_bit(START_READY, 1'b0);
    RESETN = 1'b1;
    repeat (4) @(negedge SYS_CLK);
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    check_bit(START_BIT, 1'b0);
    PORT_ENABLE = 1'b1;
    @(negedge SYS_CLK);
    check_byte({4'h0, THIRD_CHAN_TX_DESC}, 8'h04);
    for (i = 0; i < DEPTH; i++) send(i[0]);
    @(negedge SYS_CLK);
    check_bit(START_READY, 1'b0);
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    rnd_rdy = 1'b1;
    for (i = 0; i < 12; i++) send(1'($urandom));
    k = 0;
    while ((exp_rx.size() != 0 || exp_tx.size() != 0) && k < 5000)
    begin
      @(negedge SYS_CLK);
      k++;
    end
    check_bit(RX_VALID, 1'b0);
    check_bit(n_done == n_taken, 1'b1);
    check_bit(edges === 16'(8 * n_taken), 1'b1);
    check_byte(errs, 8'h00);
    PORT_ENABLE = 1'b0;
    @(negedge SYS_CLK);
    check_byte({4'h0, THIRD_CHAN_TX_DESC}, 8'h08);
    if (k >= 5000) failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
